// file: src/cpu_port_device.sv
// Contract
// - count mode decrements length per data read
// - codes 1 to 5 select endpoints one-five
// - processor never selects endpoint zero
// - no reselect mid buffer transfer
// - leave IN only when valid equals not-ready
// - leave OUT only when valid differs not-ready
// - IN valid marks committed data for engine
// - valid set when written bytes exceed max
// - short packet: processor writes valid afterwards
// - valid plus clear gives zero-length packet
// - OUT valid shows readable received data
// - valid meaningful only while not-ready low
// - valid writes of zero ignored, OUT ignores one
// - not-ready low only while port accessible
// - count down one byte mode, two word
// - clear discards data and valid state

// two-entry buffer, valid/ready both sides
module buf2_fifo #(
	parameter int W = 16
) (
	input  wire logic         ref_clk,
	input  wire logic         nrst,
	input  wire logic         flush,    // drop everything held
	input  wire logic [W-1:0] inData,
	input  wire logic         inValid,
	output logic              inReady,
	output logic [W-1:0]      outData,
	output logic              outValid,
	input  wire logic         outReady
);
	typedef struct packed {
		logic [1:0][W-1:0] mem;   // the two slots
		logic              wrPtr;
		logic              rdPtr;
		logic [1:0]        count;
	} fifo_state_type;
	fifo_state_type s_r;
	fifo_state_type s_nxt;
	logic           push;
	logic           pop;

	// handshakes straight from occupancy
	assign inReady  = (s_r.count != 2'd2);
	assign outValid = (s_r.count != 2'd0);
	assign outData  = s_r.mem[s_r.rdPtr];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	// next state
	always_comb begin
		s_nxt = s_r;
		if (push) begin
			s_nxt.mem[s_r.wrPtr] = inData;
			s_nxt.wrPtr          = ~s_r.wrPtr;
		end
		if (pop) begin
			s_nxt.rdPtr = ~s_r.rdPtr;
		end
		s_nxt.count = s_r.count + {1'b0, push} - {1'b0, pop};
		// flush wins: a cleared buffer must not leak a word
		if (flush) begin
			s_nxt.count = 2'd0;
			s_nxt.rdPtr = s_nxt.wrPtr;
		end
	end

	// state register
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule // buf2_fifo

module cpu_port_device (
	input  wire logic                   ref_clk,
	input  wire logic                   nrst,
	cpu_port_if.device                  bus,
	input  wire cpu_port_pkg::ep_mask_type epIsIn,     // direction per endpoint
	input  wire cpu_port_pkg::ep_mps_type  epMaxPkt,   // max_packet_size per endpoint
	input  wire logic                   byteMode,     // 8-bit data port mode
	input  wire logic                   outRxDone,    // engine finished an OUT packet
	input  wire cpu_port_pkg::ep_num_type  outRxEp,
	input  wire logic [10:0]            outRxLen,
	input  wire cpu_port_pkg::ep_mask_type inTaken,    // engine consumed an IN buffer
	output logic [15:0]                 txData,       // IN words toward the engine
	output cpu_port_pkg::ep_num_type    txEp,
	output logic                        txValid,
	input  wire logic                   txReady,
	input  wire logic [15:0]            rxData,       // OUT words from the engine
	input  wire logic                   rxValid,
	output logic                        rxReady,
	output cpu_port_pkg::ep_mask_type   bufValidOut   // committed IN buffers
);
	import cpu_port_pkg::*;

	typedef struct packed {
		logic                         read_count_mode;      // read_count_mode
		logic [3:0]                   epSel;     // cpu_port_endpoint_select
		ep_mask_type                  bufValid;  // buffer_valid per endpoint
		logic [EP_HI:EP_LO][LEN_W-1:0] wrCount;  // IN bytes written
		logic [EP_HI:EP_LO][LEN_W-1:0] rxLen;    // OUT packet length
		logic [EP_HI:EP_LO][LEN_W-1:0] rxRemain; // OUT bytes still unread
		logic [15:0]                  rdData;
		logic                         rdValid;
	} dev_state_type;
	dev_state_type s_r;
	dev_state_type s_nxt;

	logic        selOk;       // select code names a real endpoint
	ep_num_type  cur;         // selected endpoint
	logic        curIn;       // selected endpoint is IN
	logic        notReady;    // not-ready flag of the selected endpoint
	logic [10:0] step;        // bytes per data-port access
	logic        wrSel;
	logic        wrCtl;
	logic        dataWr;      // accepted data-port write
	logic        dataRd;      // accepted data-port read
	logic        clrHit;      // buffer_clear written as one
	logic        txInReady;
	logic        rxOutValid;
	logic [15:0] rxOutData;
	logic [18:0] txWord;
	logic [10:0] lenShown;

	// endpoint code decode, used for access and status
	function automatic logic ep_code_ok(input logic [3:0] code);
		return (code >= 4'h1) && (code <= 4'h5);
	endfunction

	assign selOk    = ep_code_ok(s_r.epSel);
	assign cur      = s_r.epSel[2:0];
	assign curIn    = selOk && epIsIn[cur];
	assign step     = byteMode ? STEP_BYTE : STEP_WORD;
	assign wrSel    = bus.wrStb && (bus.addr == ADDR_SELECT);
	assign wrCtl    = bus.wrStb && (bus.addr == ADDR_CONTROL);
	assign clrHit   = wrCtl && bus.wrData[CTL_CLEAR_BIT] && selOk;
	// port closed while the engine owns the buffer or the path is stalled
	assign notReady = !selOk || (curIn ? (s_r.bufValid[cur] || !txInReady)
		: !(s_r.bufValid[cur] && rxOutValid));
	// direction-wrong accesses are dropped, as is anything while not ready
	assign dataWr   = bus.wrStb && (bus.addr == ADDR_DATA) && curIn && !notReady;
	assign dataRd   = bus.rdStb && (bus.addr == ADDR_DATA) && selOk && !curIn && !notReady;
	assign txWord   = {cur, bus.wrData};
	// without count mode the length only drops to zero once all is read;
	// no endpoint selected: the index is out of range, so show zero instead
	assign lenShown = !selOk ? LEN_RESET
		: s_r.read_count_mode ? s_r.rxRemain[cur]
		: ((s_r.rxRemain[cur] == LEN_RESET) ? LEN_RESET : s_r.rxLen[cur]);

	// IN path toward the engine; its ready gates the not-ready flag
	buf2_fifo #(.W(19)) txBuf (
		.ref_clk  (ref_clk),
		.nrst     (nrst),
		.flush    (clrHit && curIn),
		.inData   (txWord),
		.inValid  (dataWr),
		.inReady  (txInReady),
		.outData  ({txEp, txData}),
		.outValid (txValid),
		.outReady (txReady)
	);

	// OUT path from the engine; a stalled processor holds the engine off
	buf2_fifo #(.W(16)) rxBuf (
		.ref_clk  (ref_clk),
		.nrst     (nrst),
		.flush    (clrHit && !curIn),
		.inData   (rxData),
		.inValid  (rxValid),
		.inReady  (rxReady),
		.outData  (rxOutData),
		.outValid (rxOutValid),
		.outReady (dataRd)
	);

	assign bufValidOut = s_r.bufValid & epIsIn;

	// next state: registers, per-endpoint flags, read answer
	always_comb begin
		s_nxt         = s_r;
		s_nxt.rdValid = 1'b0;
		// select register; reserved bits are not stored
		if (wrSel) begin
			s_nxt.read_count_mode  = bus.wrData[SEL_READ_COUNT_MODE_BIT];
			s_nxt.epSel = bus.wrData[SEL_EP_LSB +: 4];
		end
		for (int e = EP_LO; e <= EP_HI; e++) begin
			logic        hit;
			logic [10:0] newCnt;
			hit    = selOk && (cur == e[2:0]);
			newCnt = s_r.wrCount[e] + step;
			if (epIsIn[e]) begin
				// engine took the packet: buffer free again
				if (inTaken[e]) begin
					s_nxt.bufValid[e] = 1'b0;
					s_nxt.wrCount[e]  = LEN_RESET;
				end
				if (hit && dataWr) begin
					s_nxt.wrCount[e] = newCnt;
					if (newCnt > {1'b0, epMaxPkt[e]}) begin
						s_nxt.bufValid[e] = 1'b1;
					end
				end
				if (hit && clrHit) begin
					s_nxt.bufValid[e] = 1'b0;
					s_nxt.wrCount[e]  = LEN_RESET;
				end
				// set after clear: both together commit an empty packet
				if (hit && wrCtl && bus.wrData[CTL_VALID_BIT]) begin
					s_nxt.bufValid[e] = 1'b1;
				end
			end else begin
				// writes to buffer_valid have no effect on OUT
				if (hit && dataRd) begin
					if (s_r.rxRemain[e] <= step) begin
						s_nxt.rxRemain[e] = LEN_RESET;
						s_nxt.bufValid[e] = 1'b0;
					end else begin
						s_nxt.rxRemain[e] = s_r.rxRemain[e] - step;
					end
				end
				if (hit && clrHit) begin
					s_nxt.bufValid[e] = 1'b0;
					s_nxt.rxRemain[e] = LEN_RESET;
					s_nxt.rxLen[e]    = LEN_RESET;
				end
				// arrival wins over a clear in the same cycle
				if (outRxDone && (outRxEp == e[2:0])) begin
					s_nxt.bufValid[e] = 1'b1;
					s_nxt.rxLen[e]    = outRxLen;
					s_nxt.rxRemain[e] = outRxLen;
				end
			end
		end
		// read answer, one cycle later; reserved bits are zero
		if (bus.rdStb) begin
			s_nxt.rdValid = 1'b1;
			unique case (bus.addr)
				ADDR_SELECT: begin
					s_nxt.rdData = {s_r.read_count_mode, 11'h000, s_r.epSel};
				end
				ADDR_CONTROL: begin
					s_nxt.rdData = {2'b00, selOk && s_r.bufValid[cur], 1'b0, notReady,
						curIn ? LEN_RESET : lenShown};
				end
				ADDR_DATA: begin
					s_nxt.rdData = dataRd ? rxOutData : 16'h0000;
				end
				default: begin
					s_nxt.rdData = 16'h0000;
				end
			endcase
		end
	end

	assign bus.rdData  = s_r.rdData;
	assign bus.rdValid = s_r.rdValid;

	// state register
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			s_r       <= '0;
			s_r.read_count_mode  <= READ_COUNT_MODE_RESET;
			s_r.epSel <= EP_SEL_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule // cpu_port_device

// file: src/cpu_port_pkg.sv
package cpu_port_pkg;
	// register map of the processor port
	localparam logic [7:0]  ADDR_SELECT   = 8'h40;  // endpoint select register
	localparam logic [7:0]  ADDR_CONTROL  = 8'h42;  // buffer control register
	localparam logic [7:0]  ADDR_DATA     = 8'h44;  // endpoint data port
	// select register fields
	localparam int          SEL_READ_COUNT_MODE_BIT  = 15;     // read_count_mode
	localparam int          SEL_EP_LSB    = 0;      // endpoint code, 4 bits
	localparam logic        READ_COUNT_MODE_RESET    = 1'b0;
	localparam logic [3:0]  EP_SEL_RESET  = 4'h0;
	// control register fields
	localparam int          CTL_VALID_BIT = 13;     // buffer_valid
	localparam int          CTL_CLEAR_BIT = 12;     // buffer_clear
	localparam int          CTL_NRDY_BIT  = 11;     // not-ready
	localparam int          LEN_W         = 11;     // cpu_receive_length width
	localparam logic [10:0] LEN_RESET     = 11'h000;
	// endpoint range reachable through this port
	localparam int          EP_LO         = 1;
	localparam int          EP_HI         = 5;
	localparam int          MPS_W         = 10;     // max_packet_size width
	// per-read count-down steps
	localparam logic [10:0] STEP_BYTE     = 11'h001;
	localparam logic [10:0] STEP_WORD     = 11'h002;
	typedef logic [EP_HI:EP_LO]            ep_mask_type;
	typedef logic [EP_HI:EP_LO][MPS_W-1:0] ep_mps_type;
	typedef logic [2:0]                    ep_num_type;
endpackage

// file: src/cpu_port_if.sv
interface cpu_port_if;
	logic [7:0]  addr;    // register address
	logic        wrStb;   // one-cycle write strobe
	logic        rdStb;   // one-cycle read strobe
	logic [15:0] wrData;  // write data
	logic [15:0] rdData;  // read data, valid with rdValid
	logic        rdValid; // one cycle after rdStb
	modport device(input addr, input wrStb, input rdStb, input wrData,
		output rdData, output rdValid);
	modport host(output addr, output wrStb, output rdStb, output wrData,
		input rdData, input rdValid);
endinterface

// file: src/cpu_port_host.sv
// processor end: turns user commands into register cycles and guards
// endpoint switching
module cpu_port_host (
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	cpu_port_if.host         bus,
	input  wire logic        cmdValid,    // user command request
	output logic             cmdReady,
	input  wire logic        cmdWrite,
	input  wire logic [7:0]  cmdAddr,
	input  wire logic [15:0] cmdData,
	input  wire logic        curIsIn,     // direction of currently selected endpoint
	output logic             respValid,   // one-cycle completion
	output logic             respRefused, // command not issued
	output logic [15:0]      respData,
	output logic             dataUsable   // valid seen with not-ready low
);
	import cpu_port_pkg::*;

	typedef enum logic [3:0] {
		IDLE   = 4'b0001,
		CHECKW = 4'b0010,
		WAITRD = 4'b0100,
		DONE   = 4'b1000
	} host_fsm_type;

	typedef struct packed {
		host_fsm_type state;
		logic [7:0]   addr;
		logic         wrStb;
		logic         rdStb;
		logic [15:0]  wrData;
		logic         isWrite;
		logic         refused;
		logic [15:0]  resp;
		logic         usable;
	} host_state_type;
	host_state_type s_r;
	host_state_type s_nxt;

	logic ivSeen;  // buffer_valid from the status read
	logic nrSeen;  // not-ready from the status read
	logic safe;

	assign ivSeen = bus.rdData[CTL_VALID_BIT];
	assign nrSeen = bus.rdData[CTL_NRDY_BIT];
	// a buffer is idle or fully handed over: no transfer is half done
	assign safe   = curIsIn ? (ivSeen == nrSeen)
		: (ivSeen != nrSeen);

	// next state
	always_comb begin
		s_nxt       = s_r;
		s_nxt.wrStb = 1'b0;
		s_nxt.rdStb = 1'b0;
		unique case (s_r.state)
			IDLE: begin
				if (cmdValid) begin
					s_nxt.isWrite = cmdWrite;
					s_nxt.wrData  = cmdData;
					s_nxt.refused = 1'b0;
					if (cmdWrite && (cmdAddr == ADDR_SELECT)) begin
						if (cmdData[3:0] == 4'h0 || cmdData[3:0] > 4'h5) begin
							s_nxt.refused = 1'b1;
							s_nxt.state   = DONE;
						end else begin
							// status check before switching
							s_nxt.addr  = ADDR_CONTROL;
							s_nxt.rdStb = 1'b1;
							s_nxt.state = CHECKW;
						end
					end else begin
						s_nxt.addr  = cmdAddr;
						s_nxt.wrStb = cmdWrite;
						s_nxt.rdStb = !cmdWrite;
						s_nxt.state = cmdWrite ? DONE : WAITRD;
					end
				end
			end
			CHECKW: begin
				if (bus.rdValid) begin
					if (safe) begin
						s_nxt.addr  = ADDR_SELECT;
						s_nxt.wrStb = 1'b1;
					end else begin
						s_nxt.refused = 1'b1;
					end
					s_nxt.state = DONE;
				end
			end
			WAITRD: begin
				if (bus.rdValid) begin
					s_nxt.resp = bus.rdData;
					if (s_r.addr == ADDR_CONTROL) begin
						s_nxt.usable = ivSeen && !nrSeen;
					end
					s_nxt.state = DONE;
				end
			end
			DONE: begin
				s_nxt.state = IDLE;
			end
		endcase
	end

	// handshake outputs from state
	assign cmdReady    = (s_r.state == IDLE);
	assign respValid   = (s_r.state == DONE);
	assign respRefused = s_r.refused;
	assign respData    = s_r.resp;
	assign dataUsable  = s_r.usable;
	assign bus.addr    = s_r.addr;
	assign bus.wrStb   = s_r.wrStb;
	assign bus.rdStb   = s_r.rdStb;
	assign bus.wrData  = s_r.wrData;

	// state register
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			s_r       <= '0;
			s_r.state <= IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule // cpu_port_host

// file: bench/cpu_endpoint_fifo_port_control_assertions.sv
// watches the register bus between processor end and device end
module cpu_endpoint_fifo_port_control_assertions
	import cpu_port_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        nrst,
	input wire logic [7:0]  addr,
	input wire logic        wrStb,
	input wire logic        rdStb,
	input wire logic [15:0] wrData,
	input wire logic [15:0] rdData,
	input wire logic        rdValid
);
	logic [3:0] selEp_r;  // endpoint code last written
	logic       read_count_mode_r;   // count mode last written
	logic       selOk;    // a real endpoint is selected
	logic       ctlRd;    // control register read
	assign selOk = selEp_r >= 4'h1 && selEp_r <= 4'h5;
	assign ctlRd = rdStb && addr == ADDR_CONTROL;
	// shadow of the select register
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			selEp_r <= 4'h0;
			read_count_mode_r  <= 1'b0;
		end else if (wrStb && addr == ADDR_SELECT) begin
			selEp_r <= wrData[3:0];
			read_count_mode_r  <= wrData[SEL_READ_COUNT_MODE_BIT];
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	read_answer_a: assert property (rdStb |=> rdValid)
		else $error("read not answered");
	answer_cause_a: assert property (rdValid |-> $past(rdStb))
		else $error("answer without read");
	select_code_a: assert property (wrStb && addr == ADDR_SELECT |-> wrData[3:0] inside {[1:5]})
		else $error("bad endpoint code written");
	switch_check_a: assert property (wrStb && addr == ADDR_SELECT |-> $past(ctlRd, 2))
		else $error("switch without status read");
	select_back_a: assert property (rdStb && addr == ADDR_SELECT |=>
		rdData == {read_count_mode_r, 11'h000, selEp_r})
		else $error("select readback wrong");
	control_zero_a: assert property (ctlRd |=> rdData[15:14] == 2'b00 && !rdData[12])
		else $error("control reserved bits set");
	no_endpoint_a: assert property (ctlRd && !selOk |=> rdData[11] && !rdData[13])
		else $error("ready with no endpoint");
	refused_data_a: assert property (rdStb && addr == ADDR_DATA && !selOk |=> rdData == 16'h0000)
		else $error("data read with no endpoint");
	unmapped_read_a: assert property (rdStb && !(addr inside {8'h40, 8'h42, 8'h44})
		|=> rdData == 16'h0000)
		else $error("unmapped read not zero");
	// main traffic kinds
	cover property (wrStb && addr == ADDR_SELECT);
	cover property (ctlRd && selOk);
	cover property (rdStb && addr == ADDR_DATA && selOk);
	cover property (wrStb && addr == ADDR_DATA);
endmodule // cpu_endpoint_fifo_port_control_assertions

// file: bench/cpu_endpoint_fifo_port_control_test.sv
module cpu_endpoint_fifo_port_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	import cpu_port_pkg::*;
	logic        ref_clk = 1'b0, nrst = 1'b0, stall = 1'b1, byteMode = 1'b0;
	logic        cmdValid = 1'b0, cmdWrite = 1'b0, cmdReady, respValid, respRefused, dataUsable;
	logic        outRxDone = 1'b0, txValid, txReady = 1'b0, rxValid = 1'b0, rxReady, curIsIn;
	logic [7:0]  cmdAddr = 8'h00;
	logic [15:0] cmdData = 16'h0000, respData, txData, rxData = 16'h0000;
	logic [10:0] outRxLen = 11'h000;
	ep_num_type  outRxEp = 3'h0, txEp;
	ep_mask_type inTaken = 5'h00, bufValidOut;
	ep_mask_type epIsIn = 5'h15;              // 1,3,5 IN; 2,4 OUT
	ep_mps_type  epMaxPkt = {5{10'h004}};     // small packets keep runs short
	int          num_errors = 0, num_checks = 0, curEp = 0, epBad = 0;
	logic [15:0] txExp[$], txSeen[$], rxQ[$], rxExp[$];
	assign curIsIn = (curEp >= 1 && curEp <= 5) ? epIsIn[curEp] : 1'b0;
	cpu_port_if busIf();
	cpu_port_host i_cpu_port_host(.ref_clk(ref_clk), .nrst(nrst), .bus(busIf),
		.cmdValid(cmdValid), .cmdReady(cmdReady), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr),
		.cmdData(cmdData), .curIsIn(curIsIn), .respValid(respValid),
		.respRefused(respRefused), .respData(respData), .dataUsable(dataUsable));
	cpu_port_device i_cpu_port_device(.ref_clk(ref_clk), .nrst(nrst), .bus(busIf),
		.epIsIn(epIsIn), .epMaxPkt(epMaxPkt), .byteMode(byteMode), .outRxDone(outRxDone),
		.outRxEp(outRxEp), .outRxLen(outRxLen), .inTaken(inTaken), .txData(txData),
		.txEp(txEp), .txValid(txValid), .txReady(txReady), .rxData(rxData),
		.rxValid(rxValid), .rxReady(rxReady), .bufValidOut(bufValidOut));
	cpu_endpoint_fifo_port_control_assertions i_chk(.ref_clk(ref_clk), .nrst(nrst),
		.addr(busIf.addr), .wrStb(busIf.wrStb), .rdStb(busIf.rdStb), .wrData(busIf.wrData),
		.rdData(busIf.rdData), .rdValid(busIf.rdValid));
	always #10 ref_clk = ~ref_clk;
	// engine side: random tx stalls, rx words offered from a queue
	always @(posedge ref_clk) begin
		if (txValid && txReady) begin
			txSeen.push_back(txData);
			// only endpoint one is ever filled
			if (txEp !== 3'h1)
				epBad++;
		end
		if (rxValid && rxReady)
			void'(rxQ.pop_front());
		txReady <= !stall && ($urandom_range(1) == 1);
		rxValid <= rxQ.size() != 0;
		rxData  <= (rxQ.size() != 0) ? rxQ[0] : ~rxData;  // no stale word when idle
	end
	task automatic end_sim();
		if (num_errors == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(string n, logic [15:0] s, logic [15:0] e);
		num_checks++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	// control word as the device should show it
	function automatic logic [15:0] ctl(logic v, logic nr, logic [10:0] n);
		return {2'b00, v, 1'b0, nr, n};
	endfunction
	// one user command, bounded waits on ready and completion
	task automatic cmd(logic w, logic [7:0] a, logic [15:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		cmdValid <= 1'b1;
		cmdWrite <= w;
		cmdAddr  <= a;
		cmdData  <= d;
		@(negedge ref_clk);
		while (!cmdReady && n < 40) begin
			@(negedge ref_clk);
			n++;
		end
		@(posedge ref_clk);
		cmdValid <= 1'b0;
		while (respValid !== 1'b1 && n < 40) begin
			@(negedge ref_clk);
			n++;
		end
		if (n >= 40) begin
			num_errors++;
			end_sim();
		end
	endtask
	task automatic rdc(string n, logic [15:0] e);
		cmd(1'b0, ADDR_CONTROL, 16'h0000);
		chk(n, respData, e);
	endtask
	task automatic pick(int e, logic rc);
		cmd(1'b1, ADDR_SELECT, {rc, 11'h000, 4'(e)});
		chk("pick", {15'h0000, respRefused}, 16'h0000);
		curEp = e;
	endtask
	task automatic bv(logic e);
		repeat (2) @(negedge ref_clk);
		chk("bufValid", {15'h0000, bufValidOut[1]}, {15'h0000, e});
	endtask
	task automatic waitTx(int k);
		for (int n = 0; n < 200 && txSeen.size() < k; n++)
			@(negedge ref_clk);
		if (txSeen.size() < k) begin
			num_errors++;
			end_sim();
		end
	endtask
	task automatic take();
		@(posedge ref_clk);
		inTaken <= 5'h01;
		@(posedge ref_clk);
		inTaken <= 5'h00;
	endtask
	// engine delivers an OUT packet to endpoint two
	task automatic rxPkt(int words, logic [10:0] len);
		for (int i = 0; i < words; i++) begin
			rxExp.push_back(16'($urandom));
			rxQ.push_back(rxExp[$]);
		end
		@(posedge ref_clk);
		outRxEp   <= 3'h2;
		outRxLen  <= len;
		outRxDone <= 1'b1;
		@(posedge ref_clk);
		outRxDone <= 1'b0;
		repeat (4) @(negedge ref_clk);
	endtask
	initial begin
		void'($urandom(13126));
		repeat (12) @(posedge ref_clk);
		nrst <= 1'b1;
		cmd(1'b0, ADDR_SELECT, 16'h0000);
		chk("select", respData, 16'h0000);
		rdc("ctl reset", ctl(1'b0, 1'b1, 11'h000));
		cmd(1'b0, ADDR_DATA, 16'h0000);
		chk("data none", respData, 16'h0000);
		cmd(1'b0, 8'h46, 16'h0000);
		chk("unmapped", respData, 16'h0000);
		// endpoint zero and codes above five
		for (int c = 0; c < 16; c++)
			if (c == 0 || c > 5) begin
				cmd(1'b1, ADDR_SELECT, 16'(c));
				chk("refuse", {15'h0000, respRefused}, 16'h0001);
			end
		for (int e = 1; e <= 5; e++) begin
			pick(e, 1'b0);
			cmd(1'b0, ADDR_SELECT, 16'h0000);
			chk("select", respData, 16'(e));
			rdc("ctl idle", ctl(1'b0, !epIsIn[e], 11'h000));
		end
		// IN endpoint: fill while engine stalls, then pass max packet
		pick(1, 1'b0);
		repeat (4) txExp.push_back(16'($urandom));
		cmd(1'b1, ADDR_DATA, txExp[0]);
		cmd(1'b1, ADDR_DATA, txExp[1]);
		rdc("ctl full", ctl(1'b0, 1'b1, 11'h000));
		// IN buffer filled to max packet but not committed: a switch must be refused
		cmd(1'b1, ADDR_SELECT, 16'h0003);
		chk("switch mid", {15'h0000, respRefused}, 16'h0001);
		bv(1'b0);
		stall = 1'b0;
		waitTx(2);
		cmd(1'b1, ADDR_DATA, txExp[2]);
		bv(1'b1);
		take();
		bv(1'b0);
		// short packet committed by hand; a zero write changes nothing
		cmd(1'b1, ADDR_DATA, txExp[3]);
		cmd(1'b1, ADDR_CONTROL, 16'h2000);
		cmd(1'b1, ADDR_CONTROL, 16'h0000);
		bv(1'b1);
		rdc("ctl commit", ctl(1'b1, 1'b1, 11'h000));
		chk("usable commit", {15'h0000, dataUsable}, 16'h0000);
		waitTx(4);
		take();
		cmd(1'b1, ADDR_CONTROL, 16'h3000);
		bv(1'b1);
		cmd(1'b1, ADDR_CONTROL, 16'h1000);
		bv(1'b0);
		rdc("ctl clear", ctl(1'b0, 1'b0, 11'h000));
		// OUT endpoint with count mode, five bytes in three words
		pick(2, 1'b1);
		rxPkt(3, 11'h005);
		rdc("ctl rx", ctl(1'b1, 1'b0, 11'h005));
		chk("usable rx", {15'h0000, dataUsable}, 16'h0001);
		for (int i = 0; i < 3; i++) begin
			cmd(1'b0, ADDR_DATA, 16'h0000);
			chk("rx", respData, rxExp[i]);
			rdc("ctl count", ctl(i < 2, i == 2, 11'(i < 2 ? 3 - 2 * i : 0)));
		end
		cmd(1'b1, ADDR_CONTROL, 16'h2000);
		rdc("ctl out set", ctl(1'b0, 1'b1, 11'h000));
		rxPkt(1, 11'h002);
		rdc("ctl rx2", ctl(1'b1, 1'b0, 11'h002));
		cmd(1'b1, ADDR_CONTROL, 16'h1000);
		rdc("ctl flush", ctl(1'b0, 1'b1, 11'h000));
		cmd(1'b0, ADDR_DATA, 16'h0000);
		chk("data flushed", respData, 16'h0000);
		// byte mode: the length drops by one per read
		@(posedge ref_clk);
		byteMode <= 1'b1;
		rxPkt(2, 11'h002);
		for (int i = 4; i < 6; i++) begin
			cmd(1'b0, ADDR_DATA, 16'h0000);
			chk("rx byte", respData, rxExp[i]);
			rdc("ctl byte", ctl(i == 4, i == 5, 11'(5 - i)));
		end
		chk("tx ep", 16'(epBad), 16'h0000);
		chk("tx count", 16'(txSeen.size()), 16'(txExp.size()));
		foreach (txExp[i])
			chk("tx", txSeen[i], txExp[i]);
		end_sim();
	end
endmodule // cpu_endpoint_fifo_port_control_test
